// ==== dbgsc_ctrl.sv ====
`timescale 1ns/1ns
// Operation
// - reached only via serial status/control commands
// - reset in background sets permit, active, clksel
// - permit stays set until normal reset
// - no background entry unless permit set
// - active bit read-only, shows background mode
// - breakpoint disabled ignores force/tag, address
// - force mode match breaks at instruction boundary
// - tag mode breaks when tagged opcode executes
// - clock select: 0 alternate, 1 bus clock
// - wait/stop blocks commands except halt and status read
// - wait/stop status bit reflects wait/stop entry
// - failure bit set on wait/stop access conflict
// - data-valid failure bit always reads zero
// - status bits ignore write-control
// - permit ignores writes in background; clksel free
// - sixteen-bit breakpoint match register
module dbgsc_ctrl #(
   parameter int AW = 16
) (
   input  wire logic                  clock_in,
   input  wire logic                  sys_rst_in,
   input  wire logic                  rst_in_bgnd_in,
   input  wire dbgsc_pkg::dbgsc_cmd_t cmd_in,
   input  wire dbgsc_pkg::dbgsc_cpu_t cpu_in,
   output logic [7:0]                 status_out,
   output logic [AW-1:0]              bkpt_rdata_out,
   output logic                       cmd_accept_out,
   output logic                       enter_bgnd_out,
   output logic                       halt_to_bgnd_out,
   output logic                       swi_out,
   output logic                       bus_clk_sel_out
);
   // ==========================================
   // state
   // every control and status bit except data-valid failure lives in a flop of its own
   logic          permit_r;
   logic          active_r;
   logic          bkpt_en_r;
   logic          force_tag_r;        // 1 force at boundary, 0 tag opcode
   logic          clksel_r;           // 0 alternate clock, 1 bus clock
   logic          wait_stop_r;        // status copy of wait/stop
   logic          wait_fail_r;        // sticky access-failure flag
   logic          halt_from_sleep_r;  // background reached by halt from wait/stop
   logic [AW-1:0] bkpt_addr_r;
   logic          addr_hit;
   logic          bkpt_req;
   logic [7:0]    status_nxt;
   logic          cmd_ok;

   // ==========================================
   // commands other than halt and status read are dropped while the cpu sleeps in wait/stop;
   // once it sits in background every command works again, so the current
   // background level is used rather than the registered status copy, which
   // would lag by a cycle and drop a command just after wake-up
   assign cmd_ok = !cpu_in.in_wait_stop || cpu_in.in_background;

   // ==========================================
   // host-written control bits
   // whole byte lands on one edge, so the breakpoint logic never sees a
   // half-written configuration
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         // reset in background restores the debug session bits
         permit_r  <= rst_in_bgnd_in;
         clksel_r  <= rst_in_bgnd_in;
         bkpt_en_r <= 1'b0;
         force_tag_r <= 1'b0;
      end else if (cmd_in.write_control && cmd_ok) begin
         // permit only ever sets; a zero written later cannot withdraw it, and
         // while in background it is frozen so it can never forbid the mode
         // the cpu already sits in
         if (!active_r && cmd_in.wdata[dbgsc_pkg::BIT_PERMIT]) begin
            permit_r <= 1'b1;
         end
         bkpt_en_r   <= cmd_in.wdata[dbgsc_pkg::BIT_BKPT_EN];
         force_tag_r <= cmd_in.wdata[dbgsc_pkg::BIT_FORCE_TAG];
         clksel_r  <= cmd_in.wdata[dbgsc_pkg::BIT_CLKSEL];
      end
   end

   // ==========================================
   // background-active follows the cpu, never the host
   // one cycle of lag against the cpu level is accepted so that the bit
   // comes from a clean flop
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         active_r <= rst_in_bgnd_in;
      end else begin
         active_r <= cpu_in.in_background;
      end
   end

   // ==========================================
   // wait/stop status and failure flags
   // the halt latch remembers that background was reached from wait/stop; it
   // must survive the cycles in which the cpu is still waking up, so it is
   // dropped only once the cpu neither sleeps nor sits in background
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         wait_stop_r       <= 1'b0;
         halt_from_sleep_r <= 1'b0;
      end else begin
         if (cmd_in.halt && cpu_in.in_wait_stop && permit_r) begin
            halt_from_sleep_r <= 1'b1;
         end else if (!cpu_in.in_background && !cpu_in.in_wait_stop) begin
            halt_from_sleep_r <= 1'b0;
         end
         wait_stop_r <= cpu_in.in_wait_stop || halt_from_sleep_r;
      end
   end

   // failure is sticky; no clear exists apart from reset, so a host that has
   // recovered still sees the flag until the next reset
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         wait_fail_r <= 1'b0;
      end else if (cpu_in.mem_cmd_fail_sleep) begin
         wait_fail_r <= 1'b1;
      end
   end

   // ==========================================
   // breakpoint match register, sixteen bits
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         bkpt_addr_r <= AW'(dbgsc_pkg::RST_BKPT);
      end else if (cmd_in.write_bkpt && cmd_ok) begin
         bkpt_addr_r <= cmd_in.wdata[AW-1:0];
      end
   end

   // registered compare keeps the wide equality off the boundary path;
   // the price is one cycle between address and hit
   dbgsc_match #(
      .AW (AW)
   ) dbgsc_match_i (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .addr_in    (cpu_in.addr),
      .match_in   (bkpt_addr_r),
      .enable_in  (bkpt_en_r),
      .hit_out    (addr_hit)
   );

   // ==========================================
   // breakpoint request
   // held force request waits for the instruction boundary; the boundary
   // consumes it, otherwise a match seen once would break again at every
   // later boundary
   logic force_pend_r;
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || !bkpt_en_r || !force_tag_r) begin
         force_pend_r <= 1'b0;
      end else if (cpu_in.instr_boundary) begin
         force_pend_r <= 1'b0;
      end else if (addr_hit) begin
         force_pend_r <= 1'b1;
      end
   end

   // tag mode only fires when the tagged opcode executes; the cpu carries the
   // tag down its queue, so a flushed tag never reaches here
   assign bkpt_req = bkpt_en_r &&
      ((force_tag_r && (force_pend_r || addr_hit) && cpu_in.instr_boundary) ||
       (!force_tag_r && cpu_in.queue_end && cpu_in.queue_tag));

   // ==========================================
   // status byte; data-valid failure tied low
   always_comb begin
      status_nxt                           = dbgsc_pkg::RST_NORMAL;
      status_nxt[dbgsc_pkg::BIT_PERMIT]    = permit_r;
      status_nxt[dbgsc_pkg::BIT_ACTIVE]    = active_r;
      status_nxt[dbgsc_pkg::BIT_BKPT_EN]   = bkpt_en_r;
      status_nxt[dbgsc_pkg::BIT_FORCE_TAG] = force_tag_r;
      status_nxt[dbgsc_pkg::BIT_CLKSEL]    = clksel_r;
      status_nxt[dbgsc_pkg::BIT_WAIT_STOP] = wait_stop_r;
      status_nxt[dbgsc_pkg::BIT_WAIT_FAIL] = wait_fail_r;
      // no slow memory exists, so no access can fail for lack of valid data
      status_nxt[dbgsc_pkg::BIT_DATA_FAIL] = 1'b0;
   end

   // ==========================================
   // registered outputs
   // status is a snapshot taken by the read command; the host sees nothing
   // newer until it reads again, which keeps the byte steady while it is
   // shifted out
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         status_out       <= dbgsc_pkg::RST_NORMAL;
         bkpt_rdata_out   <= '0;
         cmd_accept_out   <= 1'b0;
         enter_bgnd_out   <= 1'b0;
         halt_to_bgnd_out <= 1'b0;
         swi_out          <= 1'b0;
         bus_clk_sel_out  <= 1'b0;
      end else begin
         if (cmd_in.read_status) begin
            status_out <= status_nxt;
         end
         if (cmd_in.read_bkpt && cmd_ok) begin
            bkpt_rdata_out <= bkpt_addr_r;
         end
         // halt is never blocked, being the only way out of wait/stop, and the
         // status read must work there too or the wait/stop bit is useless
         cmd_accept_out   <= cmd_in.halt || cmd_in.read_status ||
                             ((cmd_in.write_control || cmd_in.read_bkpt ||
                               cmd_in.write_bkpt) && cmd_ok);
         // background entry refused unless permitted; a refused breakpoint raises swi instead, a refused halt nothing
         enter_bgnd_out   <= bkpt_req && permit_r;
         swi_out          <= bkpt_req && !permit_r;
         halt_to_bgnd_out <= cmd_in.halt && permit_r;
         bus_clk_sel_out  <= clksel_r;
      end
   end
endmodule : dbgsc_ctrl

// ==== dbgsc_ctrl_checker.sv ====
`timescale 1ns/1ns
// port-level watcher for the status/control block
module dbgsc_ctrl_checker #(
   parameter int AW = 16
) (
   input wire logic                  clock_in,
   input wire logic                  sys_rst_in,
   input wire logic                  rst_in_bgnd_in,
   input wire dbgsc_pkg::dbgsc_cmd_t cmd_in,
   input wire dbgsc_pkg::dbgsc_cpu_t cpu_in,
   input wire logic [7:0]            status_out,
   input wire logic [AW-1:0]         bkpt_rdata_out,
   input wire logic                  cmd_accept_out,
   input wire logic                  enter_bgnd_out,
   input wire logic                  halt_to_bgnd_out,
   input wire logic                  swi_out,
   input wire logic                  bus_clk_sel_out
);
   // ==========================================
   // checks, one clock domain
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   a_data_fail_zero: assert property (!status_out[0])
      else $error("data-valid failure bit set");
   a_snap_hold: assert property (!cmd_in.read_status |=> $stable(status_out))
      else $error("status moved without read");
   a_permit_sticky: assert property (status_out[7] |=> status_out[7])
      else $error("permit cleared");
   a_active_shown: assert property (cpu_in.in_background[*3] ##0 cmd_in.read_status
      |=> status_out[6]) else $error("active bit low");
   a_break_cause: assert property ((enter_bgnd_out || swi_out) |->
      $past(cpu_in.instr_boundary) || $past(cpu_in.queue_end && cpu_in.queue_tag))
      else $error("break without event");
   a_halt_cause: assert property (halt_to_bgnd_out |-> $past(cmd_in.halt))
      else $error("halt pulse without halt");
   a_halt_taken: assert property (cmd_in.halt |=> cmd_accept_out)
      else $error("halt refused");
   a_write_blocked: assert property (cmd_in.write_control && cpu_in.in_wait_stop
      && !cpu_in.in_background |=> !cmd_accept_out) else $error("write taken in wait");
   a_bkpt_back: assert property (cmd_in.write_bkpt ##2 cmd_in.read_bkpt
      |=> bkpt_rdata_out == $past(cmd_in.wdata, 3)) else $error("bkpt readback");
endmodule : dbgsc_ctrl_checker

bind dbgsc_ctrl dbgsc_ctrl_checker #(.AW(AW)) dbgsc_ctrl_checker_i (
   .clock_in(clock_in), .sys_rst_in(sys_rst_in), .rst_in_bgnd_in(rst_in_bgnd_in),
   .cmd_in(cmd_in), .cpu_in(cpu_in), .status_out(status_out), .swi_out(swi_out),
   .bkpt_rdata_out(bkpt_rdata_out), .cmd_accept_out(cmd_accept_out),
   .enter_bgnd_out(enter_bgnd_out), .halt_to_bgnd_out(halt_to_bgnd_out),
   .bus_clk_sel_out(bus_clk_sel_out));

// ==== dbgsc_host.sv ====
`timescale 1ns/1ns
// debug host: one serial command strobe per call, k picks the command
module dbgsc_host (
   input  wire logic             clock_in,
   output dbgsc_pkg::dbgsc_cmd_t cmd_out
);
   initial cmd_out = '0;
   // a gap cycle follows each strobe; stale data is inverted so it never matches
   task automatic op(input int k, input logic [15:0] d);
      dbgsc_pkg::dbgsc_cmd_t c;
      c = '0;
      c.wdata = d;
      c[20-k] = 1'b1;
      @(posedge clock_in);
      cmd_out <= c;
      @(posedge clock_in);
      cmd_out <= {5'h00, ~d};
   endtask : op
endmodule : dbgsc_host

// ==== dbgsc_match.sv ====
`timescale 1ns/1ns
// address comparator with one registered stage
module dbgsc_match #(
   parameter int AW = 16
) (
   input  wire logic          clock_in,
   input  wire logic          sys_rst_in,
   input  wire logic [AW-1:0] addr_in,
   input  wire logic [AW-1:0] match_in,
   input  wire logic          enable_in,
   output logic               hit_out
);
   // ==========================================
   // compare
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         hit_out <= 1'b0;
      end else begin
         hit_out <= enable_in && (addr_in == match_in);
      end
   end
endmodule : dbgsc_match

// ==== dbgsc_pkg.sv ====
package dbgsc_pkg;
   // ==========================================
   // register field positions
   localparam int BIT_PERMIT    = 7;
   localparam int BIT_ACTIVE    = 6;
   localparam int BIT_BKPT_EN   = 5;
   localparam int BIT_FORCE_TAG = 4;
   localparam int BIT_CLKSEL    = 3;
   localparam int BIT_WAIT_STOP = 2;
   localparam int BIT_WAIT_FAIL = 1;
   localparam int BIT_DATA_FAIL = 0;
   // ==========================================
   // reset values
   localparam logic [7:0]  RST_NORMAL   = 8'h00;
   localparam logic [7:0]  RST_IN_BGND  = 8'hC8;
   localparam logic [15:0] RST_BKPT     = 16'h0000;
   // writable control bits: permit, bkpt enable, force/tag, clock select
   localparam logic [7:0]  WR_MASK      = 8'hB8;

   // ==========================================
   // serial command strobes from the command decoder
   typedef struct packed {
      logic        read_status;
      logic        write_control;
      logic        read_bkpt;
      logic        write_bkpt;
      logic        halt;
      logic [15:0] wdata;
   } dbgsc_cmd_t;

   // ==========================================
   // processor status seen by the controller
   typedef struct packed {
      logic        in_background;
      logic        in_wait_stop;
      logic        mem_cmd_fail_sleep;
      logic        instr_boundary;
      logic        queue_end;
      logic        queue_tag;
      logic [15:0] addr;
   } dbgsc_cpu_t;
endpackage : dbgsc_pkg

// ==== tb_dbgsc_ctrl.sv ====
`timescale 1ns/1ns
module tb_dbgsc_ctrl;
   logic                  clock_in = 1'b0;
   logic                  sys_rst_in = 1'b1;
   logic                  bgnd_rst = 1'b0;
   dbgsc_pkg::dbgsc_cmd_t cmd;
   dbgsc_pkg::dbgsc_cpu_t cpu = '0;
   logic [7:0]            st;
   logic [15:0]           bk, bpa;
   logic [7:0]            wd;
   logic                  acc, ent, hlt, swi, clk_sel;
   int                    n_mismatch = 0, n_checks = 0, n_ent = 0, n_swi = 0, n_acc = 0;
   int                    n_hlt = 0, a0;
   always #5 clock_in = ~clock_in;
   dbgsc_host host_i (.clock_in(clock_in), .cmd_out(cmd));
   dbgsc_ctrl dbgsc_ctrl_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .cpu_in(cpu),
      .rst_in_bgnd_in(bgnd_rst), .cmd_in(cmd), .status_out(st), .bkpt_rdata_out(bk),
      .cmd_accept_out(acc), .enter_bgnd_out(ent), .halt_to_bgnd_out(hlt), .swi_out(swi),
      .bus_clk_sel_out(clk_sel));
   // pulses last one cycle, so they are counted rather than sampled
   always @(posedge clock_in) begin
      n_ent <= n_ent + ent;
      n_swi <= n_swi + swi;
      n_acc <= n_acc + acc;
      n_hlt <= n_hlt + hlt;
   end
   // ==========================================
   // helpers
   function automatic logic [15:0] exp_st(input logic [7:0] p, w, input logic act);
      return {8'h00, (w & 8'hB8) | p | {1'b0, act, 6'h00}};
   endfunction : exp_st
   task automatic check(input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task automatic rst(input logic b);
      @(posedge clock_in);
      sys_rst_in <= 1'b1;
      bgnd_rst <= b;
      cpu <= {b, 21'h00_0000};
      repeat (10) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      @(posedge clock_in);
   endtask : rst
   task automatic rd();
      host_i.op(0, 16'h0000);
      #1;
   endtask : rd
   task automatic wr(input logic [7:0] d);
      host_i.op(1, {8'($urandom), d});
   endtask : wr
   // hold the match address, then fire a boundary (force) or queue end (tag)
   task automatic brk(input logic [7:0] d, input logic tag, input logic [15:0] ee, es);
      int e0;
      int s0;
      wr(d);
      e0 = n_ent;
      s0 = n_swi;
      cpu.addr <= bpa;
      @(posedge clock_in);
      cpu[18:16] <= {~tag, tag, tag};
      @(posedge clock_in);
      cpu[18:16] <= 3'b000;
      repeat (4) @(posedge clock_in);
      cpu.addr <= ~bpa;
      #1;
      check(16'(n_ent - e0), ee);
      check(16'(n_swi - s0), es);
   endtask : brk
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   // ==========================================
   // main sequence
   initial begin
      void'($urandom(43356));
      bpa = 16'($urandom);
      rst(1'b0);
      rd();
      check(16'(st), 16'h0000);
      check(16'(clk_sel), 16'h0000);
      host_i.op(3, bpa);
      host_i.op(2, 16'h0000);
      #1;
      check(bk, bpa);
      brk(8'h30, 1'b0, 16'h0000, 16'h0001);
      brk(8'h10, 1'b0, 16'h0000, 16'h0000);
      brk(8'hB0, 1'b0, 16'h0001, 16'h0000);
      brk(8'hA0, 1'b1, 16'h0001, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         wd = (i == 0) ? 8'h00 : 8'($urandom);
         wr(wd);
         rd();
         check(16'(st), exp_st(8'h80, wd, 1'b0));
         check(16'(clk_sel), 16'(wd[3]));
      end
      @(posedge clock_in);
      cpu[21:19] <= 3'b011;
      @(posedge clock_in);
      cpu[21:19] <= 3'b010;
      a0 = n_acc;
      wr(8'hA0);
      host_i.op(4, 16'h0000);
      @(posedge clock_in);
      cpu[21:19] <= 3'b100;
      #1;
      check(16'(n_acc - a0), 16'h0001);
      check(16'(n_hlt), 16'h0001);
      rd();
      check(16'(st[6]), 16'h0001);
      wr(8'hA0);
      rd();
      check(16'(st), exp_st(8'h80, 8'hA0, 1'b1) | 16'h0006);
      rst(1'b1);
      rd();
      check(16'(st), 16'h00C8);
      check(16'(clk_sel), 16'h0001);
      rst(1'b0);
      cpu[21] <= 1'b1;
      wr(8'h80);
      rd();
      check(16'(st), 16'h0040);
      final_report();
   end
   initial begin
      #100000;
      n_mismatch++;
      final_report();
   end
endmodule : tb_dbgsc_ctrl
